// file: tciu_pkg.sv
`default_nettype none
package tciu_pkg;
    // Bus geometry.
    localparam int ADDR_W = 8; // Byte address width.
    // Register word indices; the byte address is four times the index.
    localparam logic [5:0] IDX_FREE_COUNT_LOW_BYTE = 6'h20;
    localparam logic [5:0] IDX_FREE_COUNT_HIGH_BYTE = 6'h21;
    localparam logic [5:0] IDX_CAPTURE_BASE = 6'h22; // Rise0, fall0, rise1, fall1.
    localparam logic [5:0] IDX_INTERVAL_COUNT_LOW_BYTE = 6'h26;
    localparam logic [5:0] IDX_INTERVAL_COUNT_HIGH_NIBBLE = 6'h27;
    localparam logic [5:0] IDX_INTERVAL_RELOAD_LOW_BYTE = 6'h28;
    localparam logic [5:0] IDX_INTERVAL_RELOAD_HIGH_NIBBLE = 6'h29;
    localparam logic [5:0] IDX_CAPTURE_SETUP = 6'h2a;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h2b;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h2c;
    // Field positions of capture_setup.
    localparam int SETUP_HOLD_BIT = 7; // Keep earliest edge.
    localparam int SETUP_WIN_LSB = 4; // Three-bit window select.
    localparam int SETUP_WIDE_BIT = 3; // capture_pair_wide_enable.
    localparam logic [7:0] SETUP_WMASK = 8'hf8; // Bits 2:0 are reserved.
    // Interrupt status layout: bits 3:0 capture loads, bit 4 interval.
    localparam int IRQ_IVL_BIT = 4;
    // Values after reset.
    localparam logic [15:0] FREE_COUNT_RST = 16'h0000;
    localparam logic [11:0] INTERVAL_RST = 12'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tciu_pkg
`default_nettype wire

// file: tciu_top.sv
`timescale 1ns/100ps
`default_nettype none
module tciu_top (
    input wire logic aclk, // Timer and bus clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [tciu_pkg::ADDR_W-1:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [tciu_pkg::ADDR_W-1:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire logic [1:0] capture_in, // Capture pins, channel 0 and 1.
    output logic irq // Level interrupt request.
);
    import tciu_pkg::*;

    // True for an aligned address that falls on a mapped register.
    function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
        idx_ok = (a[1:0] == 2'h0) && (a[7:2] >= IDX_FREE_COUNT_LOW_BYTE)
            && (a[7:2] <= IDX_IRQ_MASK);
    endfunction : idx_ok

    // Bus slave state.
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
    logic aw_have_q, w_have_q; // Address or data held for a write.
    logic [5:0] wr_idx_q; // Word index of the held write.
    logic wr_ok_q; // Held write address is mapped.
    logic [7:0] wr_byte_q; // Low byte of the held write data.
    logic wr_lane_q; // Low byte lane was strobed.
    logic [1:0] bresp_q, rresp_q; // Latched responses.
    logic [31:0] rdata_q; // Latched read data.
    // Timer state.
    logic [15:0] cnt_q; // Free-running count.
    logic [7:0] fc_lo_buf_q; // Low byte waiting for its high byte.
    logic [7:0] fc_hi_snap_q; // High byte caught at the low read.
    logic [11:0] ivl_q; // Interval down counter.
    logic [7:0] rld_lo_q; // Reload low byte.
    logic [3:0] rld_hi_q; // Reload high nibble.
    logic [3:0] ihi_snap_q; // Interval high nibble caught at the low read.
    logic [7:0] setup_q; // capture_setup contents.
    logic [1:0] pin_prev_q; // Capture pins one cycle earlier.
    logic [7:0] cap_q [4]; // Capture data registers.
    logic [3:0] full_q; // Capture register holds an unread time.
    logic [4:0] st_q, msk_q; // Sticky status and its mask.

    // Handshake decode.
    wire aw_take = awvalid & awready_q;
    wire w_take = wvalid & wready_q;
    wire ar_take = arvalid & arready_q;
    wire do_wr = aw_have_q & w_have_q & ~bvalid_q;
    wire aw_have_d = (aw_have_q | aw_take) & ~do_wr;
    wire w_have_d = (w_have_q | w_take) & ~do_wr;
    wire bvalid_d = do_wr | (bvalid_q & ~bready);
    wire rvalid_d = ar_take | (rvalid_q & ~rready);
    wire we = do_wr & wr_ok_q & wr_lane_q;
    wire [5:0] rd_idx = araddr[7:2];
    wire rd_go = ar_take & idx_ok(araddr);

    // Register write strobes.
    wire wr_fc_lo = we & (wr_idx_q == IDX_FREE_COUNT_LOW_BYTE);
    wire wr_fc_hi = we & (wr_idx_q == IDX_FREE_COUNT_HIGH_BYTE);
    wire wr_rld_lo = we & (wr_idx_q == IDX_INTERVAL_RELOAD_LOW_BYTE);
    wire wr_rld_hi = we & (wr_idx_q == IDX_INTERVAL_RELOAD_HIGH_NIBBLE);
    wire wr_setup = we & (wr_idx_q == IDX_CAPTURE_SETUP);
    wire wr_status = we & (wr_idx_q == IDX_IRQ_STATUS);
    wire wr_mask = we & (wr_idx_q == IDX_IRQ_MASK);
    // Reads with a side effect.
    wire rd_fc_lo = rd_go & (rd_idx == IDX_FREE_COUNT_LOW_BYTE);
    wire rd_ivl_lo = rd_go & (rd_idx == IDX_INTERVAL_COUNT_LOW_BYTE);

    // Timer next values; a software write of the high byte wins over the tick.
    wire [15:0] cnt_d = wr_fc_hi ? {wr_byte_q, fc_lo_buf_q} : 16'(cnt_q + 16'h0001);
    wire ivl_tc = (ivl_q == 12'h000);
    wire [11:0] ivl_d = ivl_tc ? {rld_hi_q, rld_lo_q} : 12'(ivl_q - 12'h001);

    // Capture decode.
    wire hold = setup_q[SETUP_HOLD_BIT];
    wire wide = setup_q[SETUP_WIDE_BIT];
    wire [2:0] win_sel = setup_q[SETUP_WIN_LSB+:3];
    wire [7:0] win_val = 8'(cnt_q >> win_sel);
    wire [1:0] rise = capture_in & ~pin_prev_q;
    wire [1:0] fall = ~capture_in & pin_prev_q;
    // In wide mode channel 0 edges feed all four registers; channel 1 is idle.
    wire [3:0] edge_v = wide ? {fall[0], rise[0], fall[0], rise[0]}
                             : {fall[1], rise[1], fall[0], rise[0]};
    logic [3:0] ld; // Capture register loads this cycle.
    logic [3:0] rd_cap; // Capture register is read this cycle.

    // Each capture register loads on its edge unless hold is set and its gate flag (in wide mode that of register 0 or 1) marks an unread edge.
    for (genvar k = 0; k < 4; k++) begin : g_cap
        localparam int G = k % 2; // Gate flag in wide mode: that of register 0 or 1, which is the register itself for k below 2.
        wire gate_full = wide ? full_q[G] : full_q[k];
        wire [7:0] val = !wide ? win_val : (k < 2) ? cnt_q[7:0] : cnt_q[15:8];
        assign ld[k] = edge_v[k] & ~(hold & gate_full);
        assign rd_cap[k] = rd_go & (rd_idx == 6'(IDX_CAPTURE_BASE + 6'(k)));

        // Capture data and its unread flag; a load wins over a read clear.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cap_q[k] <= BYTE_RST;
                full_q[k] <= 1'b0;
            end else begin
                if (ld[k]) begin
                    cap_q[k] <= val;
                end
                full_q[k] <= ld[k] | (full_q[k] & ~rd_cap[k]);
            end
        end
    end

    // Read data selection.
    logic [7:0] rmux;
    always_comb begin
        rmux = BYTE_RST;
        unique case (rd_idx)
            IDX_FREE_COUNT_LOW_BYTE: rmux = cnt_q[7:0];
            IDX_FREE_COUNT_HIGH_BYTE: rmux = fc_hi_snap_q;
            IDX_INTERVAL_COUNT_LOW_BYTE: rmux = ivl_q[7:0];
            IDX_INTERVAL_COUNT_HIGH_NIBBLE: rmux = {4'h0, ihi_snap_q};
            IDX_INTERVAL_RELOAD_LOW_BYTE: rmux = rld_lo_q;
            IDX_INTERVAL_RELOAD_HIGH_NIBBLE: rmux = {4'h0, rld_hi_q};
            IDX_CAPTURE_SETUP: rmux = setup_q;
            IDX_IRQ_STATUS: rmux = {3'h0, st_q};
            IDX_IRQ_MASK: rmux = {3'h0, msk_q};
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (rd_idx == 6'(IDX_CAPTURE_BASE + 6'(i))) begin
                        rmux = cap_q[i];
                    end
                end
            end
        endcase
    end

    // Events set status bits; a set in the clearing cycle wins over the clear.
    wire [4:0] ev = {ivl_tc, ld};
    wire [4:0] st_d = (st_q & ~(wr_status ? wr_byte_q[4:0] : 5'h00)) | ev;

    // Bus handshake registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q <= ~w_have_d & ~bvalid_d;
            bvalid_q <= bvalid_d;
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Bus payload registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_idx_q <= 6'h00;
            wr_ok_q <= 1'b0;
            wr_byte_q <= BYTE_RST;
            wr_lane_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (aw_take) begin
                wr_idx_q <= awaddr[7:2];
                wr_ok_q <= idx_ok(awaddr);
            end
            if (w_take) begin
                wr_byte_q <= wdata[7:0];
                wr_lane_q <= wstrb[0];
            end
            if (do_wr) begin
                bresp_q <= wr_ok_q ? RESP_OKAY : RESP_SLVERR;
            end
            if (ar_take) begin
                rdata_q <= rd_go ? {24'h00_0000, rmux} : 32'h0000_0000;
                rresp_q <= rd_go ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Free-running timer and its byte buffers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= FREE_COUNT_RST;
            fc_lo_buf_q <= BYTE_RST;
            fc_hi_snap_q <= BYTE_RST;
        end else begin
            cnt_q <= cnt_d;
            if (wr_fc_lo) begin
                fc_lo_buf_q <= wr_byte_q;
            end
            if (rd_fc_lo) begin
                fc_hi_snap_q <= cnt_q[15:8];
            end
        end
    end

    // Interval timer, reload and snapshot.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ivl_q <= INTERVAL_RST;
            rld_lo_q <= BYTE_RST;
            rld_hi_q <= 4'h0;
            ihi_snap_q <= 4'h0;
        end else begin
            ivl_q <= ivl_d;
            if (wr_rld_lo) begin
                rld_lo_q <= wr_byte_q;
            end
            if (wr_rld_hi) begin
                rld_hi_q <= wr_byte_q[3:0];
            end
            if (rd_ivl_lo) begin
                ihi_snap_q <= ivl_q[11:8];
            end
        end
    end

    // Setup, pin history, status, mask and interrupt output.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_q <= BYTE_RST;
            pin_prev_q <= 2'h0;
            st_q <= 5'h00;
            msk_q <= 5'h00;
            irq_q <= 1'b0;
        end else begin
            if (wr_setup) begin
                setup_q <= wr_byte_q & SETUP_WMASK;
            end
            if (wr_mask) begin
                msk_q <= wr_byte_q[4:0];
            end
            pin_prev_q <= capture_in;
            st_q <= st_d;
            irq_q <= |(st_q & msk_q);
        end
    end

    // Outputs straight from flip-flops.
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign irq = irq_q;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_held;
        aw_have_q && w_have_q && !bvalid_q;
    endsequence
    sequence s_write_answered;
        ##1 bvalid_q ##0 (aw_have_q == 1'b0);
    endsequence

    a_write_answer: assert property (s_write_held |-> s_write_answered)
        else $error("write response missing");
    a_free_count_tick: assert property (aresetn && !wr_fc_hi
        |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
        else $error("free count did not step");
    a_free_count_write: assert property (wr_fc_hi |=> cnt_q == {$past(wr_byte_q), $past(fc_lo_buf_q)})
        else $error("free count write lost");
    a_interval_reload: assert property (ivl_tc |=> ivl_q == {$past(rld_hi_q), $past(rld_lo_q)})
        else $error("interval reload wrong");
    a_interval_event: assert property (aresetn && ivl_tc
        |=> st_q[IRQ_IVL_BIT] ##1 irq_q || !$past(msk_q[IRQ_IVL_BIT]))
        else $error("interval event lost");
    a_pit_high_snap: assert property (ar_take && rd_go && rd_idx == IDX_INTERVAL_COUNT_HIGH_NIBBLE
        |=> rdata_q == {28'h000_0000, ihi_snap_q})
        else $error("interval high not the snapshot");
    a_hold_first_edge: assert property (hold && !wide && full_q[0] && !rd_cap[0] |=> $stable(cap_q[0]))
        else $error("held capture overwritten");
    a_latest_edge: assert property (!hold && !wide && rise[0] |=> cap_q[0] == $past(win_val))
        else $error("latest edge not captured");
    a_wide_high_byte: assert property (!hold && wide && fall[0] |=> cap_q[3] == $past(cnt_q[15:8]))
        else $error("wide capture high byte wrong");
    a_channel1_idle: assert property (wide && !rise[0] && !fall[0] |=> $stable(cap_q[2]) && $stable(cap_q[3]))
        else $error("channel 1 moved in wide mode");
    a_capture_status: assert property (ld[1] |=> st_q[1])
        else $error("capture load did not set status");
endmodule : tciu_top
`default_nettype wire

// file: tciu_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// Stands in for the signal sources on the two capture pins.
module tciu_pin_model (
    input wire logic aclk, // Timer clock.
    output logic [1:0] capture_in // Pin levels, channel 0 and 1.
);
    // Both pins rest low, so reset never sees a false rising edge.
    initial begin
        capture_in = 2'h0;
    end
    // Raise pin ch for hi cycles, then keep it low for lo cycles.
    task automatic pulse(input int ch, input int hi, input int lo);
        capture_in[ch] <= 1'b1;
        repeat (hi) @(posedge aclk);
        capture_in[ch] <= 1'b0;
        repeat (lo) @(posedge aclk);
    endtask : pulse
endmodule : tciu_pin_model
`default_nettype wire

// file: timer_capture_interval_unit_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module timer_capture_interval_unit_tb_top;
    import tciu_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, irq;
    logic awready, wready, arready;
    logic [7:0] awaddr, araddr; // Byte addresses.
    logic [31:0] wdata, rdata, d, e; // Bus data and scratch words.
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, capture_in;
    int errors, samples_checked, cyc, t_take;
    tciu_top i_tciu_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .capture_in(capture_in), .irq(irq));
    tciu_pin_model i_tciu_pin_model (.aclk(aclk), .capture_in(capture_in));
    // The clock runs at 10 MHz.
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Cycle counter; it stamps bus takes and cuts a hang short.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            summarize();
        end
    end
    // Compare one value and count the result.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One AXI4-Lite write; address and data are offered together.
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a && w)) begin
            @(posedge aclk);
            if (awready && !a) begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
        check(bresp, RESP_OKAY);
    endtask : wr
    // One AXI4-Lite read; the take cycle is kept in t_take.
    task automatic rd(input logic [5:0] idx);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        t_take = cyc;
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // Reset values, a reserved field, and an unmapped address.
    task automatic t_reset();
        rd(IDX_CAPTURE_SETUP); check(d, 32'h0);
        rd(IDX_IRQ_MASK); check(d, 32'h0);
        wr(IDX_INTERVAL_RELOAD_HIGH_NIBBLE, 8'hfa);
        rd(IDX_INTERVAL_RELOAD_HIGH_NIBBLE); check(d, 32'h0a);
        rd(6'h30); check(r, RESP_SLVERR);
    endtask : t_reset
    // Free count: a paired write commits, then it counts and wraps.
    task automatic t_free();
        wr(IDX_FREE_COUNT_LOW_BYTE, 8'h34);
        wr(IDX_FREE_COUNT_HIGH_BYTE, 8'h12);
        rd(IDX_FREE_COUNT_LOW_BYTE);
        rd(IDX_FREE_COUNT_HIGH_BYTE); check(d, 32'h12);
        wr(IDX_FREE_COUNT_LOW_BYTE, 8'hf0);
        wr(IDX_FREE_COUNT_HIGH_BYTE, 8'hff);
        repeat (100) @(posedge aclk);
        rd(IDX_FREE_COUNT_LOW_BYTE);
        rd(IDX_FREE_COUNT_HIGH_BYTE); check(d, 32'h0);
    endtask : t_free
    // Every window code; odd codes keep the earliest edge, even the latest.
    task automatic t_window();
        logic [7:0] rise;
        for (int n = 0; n < 8; n++) begin
            wr(IDX_CAPTURE_SETUP, {n[0], n[2:0], 4'h0});
            rd(IDX_CAPTURE_BASE);
            rd(IDX_CAPTURE_BASE + 6'h1);
            wr(IDX_IRQ_STATUS, 8'h0f);
            i_tciu_pin_model.pulse(0, 2 << n, 3);
            i_tciu_pin_model.pulse(0, 1 << n, 3);
            rd(IDX_CAPTURE_BASE); rise = d[7:0];
            rd(IDX_CAPTURE_BASE + 6'h1);
            check(8'(d[7:0] - rise), n[0] ? 8'h2 : 8'h1);
            rd(IDX_IRQ_STATUS); check(d[1:0], 2'h3);
        end
    endtask : t_window
    // Paired mode: channel 1 registers hold the upper byte; its pin is ignored.
    task automatic t_wide();
        wr(IDX_CAPTURE_SETUP, 8'h08);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_IRQ_STATUS, 8'h1f);
        check(irq, 1'b0);
        fork
            i_tciu_pin_model.pulse(0, 300, 3);
            i_tciu_pin_model.pulse(1, 7, 9);
        join
        check(irq, 1'b1);
        rd(IDX_CAPTURE_BASE); e[7:0] = d[7:0];
        rd(IDX_CAPTURE_BASE + 6'h2); e[15:8] = d[7:0];
        rd(IDX_CAPTURE_BASE + 6'h1); e[23:16] = d[7:0];
        rd(IDX_CAPTURE_BASE + 6'h3); e[31:24] = d[7:0];
        check(16'(e[31:16] - e[15:0]), 32'd300);
    endtask : t_wide
    // Interval timer: reload, event, clear, and the high nibble snapshot.
    task automatic t_interval();
        int c1, dt, v1;
        wr(IDX_INTERVAL_RELOAD_LOW_BYTE, 8'h00);
        wr(IDX_INTERVAL_RELOAD_HIGH_NIBBLE, 8'h0a);
        wr(IDX_IRQ_MASK, 8'h10);
        wr(IDX_IRQ_STATUS, 8'h1f);
        for (int i = 0; i < 2600 && !irq; i++) @(posedge aclk);
        check(irq, 1'b1);
        wr(IDX_IRQ_STATUS, 8'h10);
        check(irq, 1'b0);
        rd(IDX_INTERVAL_COUNT_LOW_BYTE); v1 = d[7:0]; c1 = t_take;
        repeat (300) @(posedge aclk);
        rd(IDX_INTERVAL_COUNT_HIGH_NIBBLE); check(d[31:4], 28'h0);
        v1 = v1 + 256 * d[3:0];
        rd(IDX_INTERVAL_COUNT_LOW_BYTE); dt = t_take - c1;
        v1 = (v1 >= dt) ? v1 - dt : v1 + 2561 - dt;
        check(d[7:0], v1[7:0]);
        wr(IDX_IRQ_MASK, 8'h00);
    endtask : t_interval
    // Print the verdict and stop.
    task automatic summarize();
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // Reset for 16 cycles, then run each scenario.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        errors = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_free();
        t_window();
        t_wide();
        t_interval();
        summarize();
    end
endmodule : timer_capture_interval_unit_tb_top
`default_nettype wire
